// ### rcb_pkg.sv
package rcb_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sizes of the controller.
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int VAL_W = 5;
    localparam int NUM_CTL = 6;
    localparam int CNT_W = 18;
    localparam int ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] RCB_CMD_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] RCB_STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] RCB_WDATA_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] RCB_RBACK_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] RCB_CHCFG_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] RCB_DUR_OFS = 8'h14;

    // Command word fields.
    localparam int CMD_CTL_LSB = 0;
    localparam int CMD_ALL_BIT = 4;
    localparam int CMD_CH_LSB = 8;
    localparam int CMD_KIND_LSB = 12;
    localparam int CMD_OP_LSB = 16;

    // Status word bits; the refused bit is write-one-to-clear.
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_DVALID_BIT = 1;
    localparam int STS_OCDONE_BIT = 2;
    localparam int STS_REFUSED_BIT = 3;

    // Reset value of the channel type map (two bits per logical channel).
    localparam logic [2*NUM_CH-1:0] RCB_CHCFG_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Command operations.
    localparam logic [1:0] OP_PMA_WR = 2'h0;
    localparam logic [1:0] OP_PMA_RD = 2'h1;
    localparam logic [1:0] OP_RECFG = 2'h2;
    localparam logic [1:0] OP_OFFCAL = 2'h3;

    // Analog control selectors; the last two are the long ones.
    localparam logic [2:0] CTL_POST1 = 3'h0;
    localparam logic [2:0] CTL_SWING = 3'h1;
    localparam logic [2:0] CTL_EQ = 3'h2;
    localparam logic [2:0] CTL_EQ_DC = 3'h3;
    localparam logic [2:0] CTL_PRETAP = 3'h4;
    localparam logic [2:0] CTL_POST2 = 3'h5;

    // Channel types in the channel map.
    localparam logic [1:0] CHT_NONE = 2'h0;
    localparam logic [1:0] CHT_TX = 2'h1;
    localparam logic [1:0] CHT_RX = 2'h2;
    localparam logic [1:0] CHT_RXTX = 2'h3;

    // Reconfiguration kinds.
    localparam logic [2:0] RK_TX = 3'h0;
    localparam logic [2:0] RK_RX = 3'h1;
    localparam logic [2:0] RK_TXRX = 3'h2;
    localparam logic [2:0] RK_PLL = 3'h3;
    localparam logic [2:0] RK_TXPLL = 3'h4;
    localparam logic [2:0] RK_FULL = 3'h5;
    localparam logic [2:0] RK_CLK_UNIT = 3'h6;
    localparam logic [2:0] RK_BAD = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Busy durations in reconfiguration clock cycles.
    localparam int DUR_WR_SHORT = 260;
    localparam int DUR_WR_LONG = 520;
    localparam int DUR_RD_SHORT = 130;
    localparam int DUR_RD_LONG = 260;
    localparam int DUR_OC_TX = 877;
    localparam int DUR_OC_NONE = 2;
    localparam int DUR_OC_SIM = 16;
    localparam int DUR_RC_TX = 1518;
    localparam int DUR_RC_PLL = 863;
    localparam int DUR_RC_TXPLL = 2370;
    localparam int DUR_RC_CLK_UNIT = 925;
    localparam int DUR_OC_RX = 18307;
    localparam int DUR_OC_SETTLE = 130000;
    localparam int DUR_RC_RX = 5255;
    localparam int DUR_RC_TXRX = 6762;
    localparam int DUR_RC_FULL = 7614;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sequencer states.
    typedef enum logic [5:0] {
        ST_PWRUP = 6'b000001,
        ST_OC_SCAN = 6'b000010,
        ST_OC_SETTLE = 6'b000100,
        ST_IDLE = 6'b001000,
        ST_PMA = 6'b010000,
        ST_RECFG = 6'b100000
    } rcb_state_t;

    // AHB-Lite request from the master and answer of this slave.
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } rcb_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } rcb_ahb_rsp_t;

    // State of the segment timer.
    typedef struct packed {
        logic [CNT_W-1:0] count;
    } rcb_tmr_t;

    // State of the controller core.
    typedef struct packed {
        rcb_state_t st;
        logic [CH_W-1:0] ch;
        logic [1:0] op;
        logic [2:0] ctl;
        logic all;
        logic [VAL_W-1:0] wval;
        logic [2*NUM_CH-1:0] chcfg;
        logic [NUM_CTL-1:0][NUM_CH-1:0][VAL_W-1:0] setting;
        logic [NUM_CH-1:0][VAL_W-1:0] rback;
        logic dvalid;
        logic ocdone;
        logic refused;
        logic [CNT_W-1:0] dur;
        logic a_valid;
        logic a_write;
        logic [ADDR_W-1:0] a_addr;
        logic [31:0] hrdata;
    } rcb_core_t;

endpackage

// ### rcb_seg_timer.sv
`timescale 1ns/1ps
// Down counter that holds run high for exactly the loaded number of cycles.
module rcb_seg_timer
    import rcb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic load_i,
    input wire logic [CNT_W-1:0] len_i,
    output logic run_o,
    output logic last_o
);

    rcb_tmr_t s_q;
    rcb_tmr_t s_d;

    ////////////////////////////////////////////////////////////////////////////////////////
    // A load in the last cycle chains segments with no gap in run.
    always_comb begin
        s_d = s_q;
        if (load_i) begin
            s_d.count = len_i;
        end else if (s_q.count != '0) begin
            s_d.count = s_q.count - CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign run_o = (s_q.count != '0);
    assign last_o = (s_q.count == CNT_W'(1));

endmodule

// ### rcb_ctrl.sv
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module rcb_ctrl
    import rcb_pkg::*;
#(
    parameter int OC_RX_CYC = DUR_OC_RX,
    parameter int OC_SETTLE_CYC = DUR_OC_SETTLE,
    parameter int RC_RX_CYC = DUR_RC_RX,
    parameter int RC_TXRX_CYC = DUR_RC_TXRX,
    parameter int RC_FULL_CYC = DUR_RC_FULL,
    parameter bit REDUCED_TIMING = 1'b0,
    parameter logic [2*NUM_CH-1:0] CH_TYPES_INIT = RCB_CHCFG_RST
)
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire rcb_ahb_req_t ahb_req_i,
    output rcb_ahb_rsp_t ahb_rsp_o,
    output logic busy_o,
    output logic data_valid_o
);

    rcb_core_t s_q;
    rcb_core_t s_d;
    logic tm_load;
    logic [CNT_W-1:0] tm_len;
    logic tm_run;
    logic tm_last;
    logic bus_wr;
    logic [31:0] wd;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Duration of one offset cancellation step, chosen by the channel type.
    function automatic logic [CNT_W-1:0] oc_len(input logic [1:0] cht);
        logic [CNT_W-1:0] n;
        n = CNT_W'(DUR_OC_NONE);
        case (cht)
            CHT_TX: n = CNT_W'(DUR_OC_TX);
            CHT_RX, CHT_RXTX: n = CNT_W'(OC_RX_CYC);
            default: n = CNT_W'(DUR_OC_NONE);
        endcase
        return n;
    endfunction

    // Busy length per channel for one analog control access.
    function automatic logic [CNT_W-1:0] pma_len(input logic [1:0] op, input logic [2:0] ctl);
        logic lng;
        logic [CNT_W-1:0] n;
        lng = (ctl == CTL_PRETAP) || (ctl == CTL_POST2);
        if (op == OP_PMA_RD) begin
            n = lng ? CNT_W'(DUR_RD_LONG) : CNT_W'(DUR_RD_SHORT);
        end else begin
            n = lng ? CNT_W'(DUR_WR_LONG) : CNT_W'(DUR_WR_SHORT);
        end
        return n;
    endfunction

    // Busy length of a channel or transmit PLL reconfiguration.
    function automatic logic [CNT_W-1:0] rc_len(input logic [2:0] kind);
        logic [CNT_W-1:0] n;
        case (kind)
            RK_TX: n = CNT_W'(DUR_RC_TX);
            RK_RX: n = CNT_W'(RC_RX_CYC);
            RK_TXRX: n = CNT_W'(RC_TXRX_CYC);
            RK_PLL: n = CNT_W'(DUR_RC_PLL);
            RK_TXPLL: n = CNT_W'(DUR_RC_TXPLL);
            RK_FULL: n = CNT_W'(RC_FULL_CYC);
            RK_CLK_UNIT: n = CNT_W'(DUR_RC_CLK_UNIT);
            default: n = '0;
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // One timer paces every busy period; segments chain without a gap.
    rcb_seg_timer u_timer (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .load_i(tm_load),
        .len_i(tm_len),
        .run_o(tm_run),
        .last_o(tm_last)
    );

    assign bus_wr = s_q.a_valid & s_q.a_write;
    assign wd = ahb_req_i.hwdata;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus slave, sequencer and command launch.
    always_comb begin
        s_d = s_q;
        tm_load = 1'b0;
        tm_len = '0;

        // Address phase is captured; read data is taken from the state seen then.
        s_d.a_valid = ahb_req_i.hsel & ahb_req_i.htrans[1] & ahb_req_i.hready;
        s_d.a_write = ahb_req_i.hwrite;
        s_d.a_addr = ahb_req_i.haddr[ADDR_W-1:0];
        if (s_d.a_valid && !ahb_req_i.hwrite) begin
            case (ahb_req_i.haddr[ADDR_W-1:0])
                // The kind field is not kept, so it reads back as zero.
                RCB_CMD_OFS: s_d.hrdata = {14'h0000, s_q.op, 6'h00, s_q.ch, 3'h0,
                    s_q.all, 1'b0, s_q.ctl};
                RCB_STATUS_OFS: s_d.hrdata = 32'({s_q.refused, s_q.ocdone, s_q.dvalid, tm_run});
                RCB_WDATA_OFS: s_d.hrdata = 32'(s_q.wval);
                RCB_RBACK_OFS: s_d.hrdata = 32'(s_q.rback);
                RCB_CHCFG_OFS: s_d.hrdata = 32'(s_q.chcfg);
                RCB_DUR_OFS: s_d.hrdata = 32'(s_q.dur);
                default: s_d.hrdata = 32'h0000_0000;
            endcase
        end

        // Count the cycles of the current busy period for software to read back.
        if (tm_run) begin
            s_d.dur = s_q.dur + CNT_W'(1);
        end

        // Sequencer.
        case (s_q.st)
            ST_PWRUP: begin
                // Busy stays low in this first cycle before the scan starts.
                tm_load = 1'b1;
                if (REDUCED_TIMING) begin
                    tm_len = CNT_W'(DUR_OC_SIM);
                    s_d.st = ST_OC_SETTLE;
                end else begin
                    tm_len = oc_len(s_q.chcfg[1:0]);
                    s_d.ch = '0;
                    s_d.st = ST_OC_SCAN;
                end
            end
            ST_OC_SCAN: begin
                if (tm_last) begin
                    tm_load = 1'b1;
                    if (s_q.ch == CH_W'(NUM_CH - 1)) begin
                        tm_len = CNT_W'(OC_SETTLE_CYC);
                        s_d.st = ST_OC_SETTLE;
                    end else begin
                        s_d.ch = s_q.ch + CH_W'(1);
                        tm_len = oc_len(s_q.chcfg[2*(s_q.ch+CH_W'(1)) +: 2]);
                    end
                end
            end
            ST_OC_SETTLE: begin
                if (tm_last) begin
                    s_d.ocdone = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_PMA: begin
                if (tm_last) begin
                    if (s_q.op == OP_PMA_WR) begin
                        s_d.setting[s_q.ctl][s_q.ch] = s_q.wval;
                    end else begin
                        s_d.rback[s_q.ch] = s_q.setting[s_q.ctl][s_q.ch];
                    end
                    if (s_q.all && (s_q.ch != CH_W'(NUM_CH - 1))) begin
                        // Broadcast walks every channel back to back, busy held high.
                        s_d.ch = s_q.ch + CH_W'(1);
                        tm_load = 1'b1;
                        tm_len = pma_len(s_q.op, s_q.ctl);
                    end else begin
                        // Valid rises in the cycle in which busy has just fallen.
                        s_d.dvalid = (s_q.op == OP_PMA_RD);
                        s_d.st = ST_IDLE;
                    end
                end
            end
            ST_RECFG: begin
                if (tm_last) begin
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase

        // Register writes in the data phase.
        if (bus_wr) begin
            case (s_q.a_addr)
                RCB_WDATA_OFS: begin
                    s_d.wval = wd[VAL_W-1:0];
                end
                RCB_CHCFG_OFS: begin
                    // The map is frozen while a sequence runs so the scan sees one view.
                    if (s_q.st == ST_IDLE) begin
                        s_d.chcfg = wd[2*NUM_CH-1:0];
                    end
                end
                RCB_STATUS_OFS: begin
                    if (wd[STS_REFUSED_BIT]) begin
                        s_d.refused = 1'b0;
                    end
                end
                RCB_CMD_OFS: begin
                    if (s_q.st != ST_IDLE) begin
                        s_d.refused = 1'b1;
                    end else if (((wd[CMD_OP_LSB +: 2] == OP_PMA_WR)
                            || (wd[CMD_OP_LSB +: 2] == OP_PMA_RD))
                            && (wd[CMD_CTL_LSB +: 3] > CTL_POST2)) begin
                        s_d.refused = 1'b1;
                    end else if ((wd[CMD_OP_LSB +: 2] == OP_RECFG)
                            && (wd[CMD_KIND_LSB +: 3] == RK_BAD)) begin
                        s_d.refused = 1'b1;
                    end else begin
                        s_d.op = wd[CMD_OP_LSB +: 2];
                        s_d.ctl = wd[CMD_CTL_LSB +: 3];
                        s_d.all = wd[CMD_ALL_BIT];
                        s_d.ch = wd[CMD_ALL_BIT] ? '0 : wd[CMD_CH_LSB +: CH_W];
                        s_d.dvalid = 1'b0;
                        s_d.dur = '0;
                        case (wd[CMD_OP_LSB +: 2])
                            OP_PMA_WR, OP_PMA_RD: begin
                                tm_load = 1'b1;
                                tm_len = pma_len(wd[CMD_OP_LSB +: 2], wd[CMD_CTL_LSB +: 3]);
                                s_d.st = ST_PMA;
                            end
                            OP_RECFG: begin
                                tm_load = 1'b1;
                                tm_len = rc_len(wd[CMD_KIND_LSB +: 3]);
                                s_d.st = ST_RECFG;
                            end
                            default: begin
                                // A rerun repeats the power-up sequence, quiet cycle included.
                                s_d.ocdone = 1'b0;
                                s_d.st = ST_PWRUP;
                            end
                        endcase
                    end
                end
                default: begin
                    s_d.wval = s_q.wval;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // State register; reset lands in the power-up state so cancellation starts by itself.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_q <= '0;
            s_q.st <= ST_PWRUP;
            s_q.chcfg <= CH_TYPES_INIT;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Zero-wait slave that always answers OKAY; unmapped reads return zero.
    assign ahb_rsp_o.hrdata = s_q.hrdata;
    assign ahb_rsp_o.hreadyout = 1'b1;
    assign ahb_rsp_o.hresp = 1'b0;

    // Busy is exactly the timer run, so every period counts whole cycles.
    assign busy_o = tm_run;
    assign data_valid_o = s_q.dvalid;

endmodule

// ### rcb_ctrl_chk_assertions.sv
`timescale 1ns/1ps
module rcb_ctrl_chk
    import rcb_pkg::*;
#(
    parameter int OC_RX_CYC = DUR_OC_RX,
    parameter int OC_SETTLE_CYC = DUR_OC_SETTLE,
    parameter int RC_RX_CYC = DUR_RC_RX,
    parameter int RC_TXRX_CYC = DUR_RC_TXRX,
    parameter int RC_FULL_CYC = DUR_RC_FULL,
    parameter bit REDUCED_TIMING = 1'b0,
    parameter logic [2*NUM_CH-1:0] CH_TYPES_INIT = RCB_CHCFG_RST
)
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire rcb_ahb_req_t ahb_req_i,
    input wire rcb_ahb_rsp_t ahb_rsp_o,
    input wire logic busy_o,
    input wire logic data_valid_o
);
    logic cmd_ap_q;
    int run_q;

    // A command is legal when its control or kind field names a real target.
    function automatic bit cmd_ok(logic [31:0] w);
        if (w[CMD_OP_LSB+:2] < 2'h2) return w[CMD_CTL_LSB+:3] <= 3'h5;
        return (w[CMD_OP_LSB+:2] == OP_OFFCAL) || (w[CMD_KIND_LSB+:3] != RK_BAD);
    endfunction

    // Every busy run must match one of the fixed durations; the map is taken as never rewritten.
    function automatic bit len_ok(int n);
        int oc;
        oc = OC_SETTLE_CYC;
        for (int c = 0; c < NUM_CH; c++) begin
            case (CH_TYPES_INIT[2*c+:2])
                CHT_TX: oc += DUR_OC_TX;
                CHT_NONE: oc += DUR_OC_NONE;
                default: oc += OC_RX_CYC;
            endcase
        end
        if (REDUCED_TIMING) oc = DUR_OC_SIM;
        return n inside {DUR_WR_SHORT, DUR_WR_LONG, DUR_RD_SHORT, 4*DUR_WR_SHORT, 4*DUR_WR_LONG,
            4*DUR_RD_SHORT, DUR_RC_TX, DUR_RC_PLL, DUR_RC_TXPLL, DUR_RC_CLK_UNIT, RC_RX_CYC,
            RC_TXRX_CYC, RC_FULL_CYC, oc};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Marks the edge that ends the data phase of a command write.
    always_ff @(posedge mclk_i) begin
        cmd_ap_q <= !srst_i && ahb_req_i.hsel && ahb_req_i.htrans[1] && ahb_req_i.hready &&
            ahb_req_i.hwrite && (ahb_req_i.haddr[ADDR_W-1:0] == RCB_CMD_OFS);
    end

    // Length of the current busy run, cleared whenever busy is low.
    always_ff @(posedge mclk_i) begin
        if (srst_i || !busy_o) run_q <= 0;
        else run_q <= run_q + 1;
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    ////////////////////////////////////////////////////////////////////////////////////////
    busy_len_a: assert property ($fell(busy_o) |-> len_ok(run_q))
        else $error("busy run length is not a documented duration");
    pwrup_low_a: assert property ($fell(srst_i) |-> !busy_o ##1 busy_o)
        else $error("busy did not start right after the quiet cycle");
    dv_after_a: assert property ($rose(data_valid_o) |-> $fell(busy_o))
        else $error("data valid rose other than as busy fell");
    dv_quiet_a: assert property (busy_o |-> !data_valid_o)
        else $error("data valid high while busy");
    busy_hold_a: assert property ($rose(busy_o) |-> busy_o [*8])
        else $error("busy dropped within eight cycles");
    cmd_start_a: assert property (cmd_ap_q && !busy_o && cmd_ok(ahb_req_i.hwdata)
        |-> ##[1:2] busy_o)
        else $error("accepted command did not raise busy");
    bad_cmd_a: assert property (cmd_ap_q && !busy_o && !cmd_ok(ahb_req_i.hwdata)
        |=> !busy_o ##1 !busy_o)
        else $error("illegal command raised busy");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(cmd_ap_q) || $past(cmd_ap_q, 2)
        || $past(srst_i, 2) || $past(srst_i, 3))
        else $error("busy rose with no command and no reset");
    okay_resp_a: assert property (ahb_rsp_o.hreadyout && !ahb_rsp_o.hresp)
        else $error("bus answer is not a ready OKAY");
endmodule

bind rcb_ctrl rcb_ctrl_chk #(.OC_RX_CYC(OC_RX_CYC), .OC_SETTLE_CYC(OC_SETTLE_CYC),
    .RC_RX_CYC(RC_RX_CYC), .RC_TXRX_CYC(RC_TXRX_CYC), .RC_FULL_CYC(RC_FULL_CYC),
    .REDUCED_TIMING(REDUCED_TIMING), .CH_TYPES_INIT(CH_TYPES_INIT)) u_chk (
    .mclk_i(mclk_i), .srst_i(srst_i), .ahb_req_i(ahb_req_i), .ahb_rsp_o(ahb_rsp_o),
    .busy_o(busy_o), .data_valid_o(data_valid_o));

// ### rcb_host_mdl.sv
`timescale 1ns/1ps
// User logic as bus master; it has no power-down control, so cancellation runs undisturbed.
module rcb_host_mdl
    import rcb_pkg::*;
(
    input wire logic mclk_i,
    output rcb_ahb_req_t req_o,
    input wire rcb_ahb_rsp_t rsp_i
);
    // Bus idle from time zero.
    initial req_o = '0;

    // One single word transfer; every change lands just after a rising edge.
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        req_o.hsel <= 1'b1;
        req_o.haddr <= 32'(a);
        req_o.htrans <= 2'b10;
        req_o.hwrite <= wr;
        req_o.hsize <= 3'b010;
        do @(posedge mclk_i); while (rsp_i.hreadyout !== 1'b1);
        req_o.hsel <= 1'b0;
        req_o.htrans <= 2'b00;
        req_o.hwdata <= wd;
        do @(posedge mclk_i); while (rsp_i.hreadyout !== 1'b1);
        rd = rsp_i.hrdata;
        // Released data shows its inverse so a stale value cannot pass.
        req_o.hwdata <= ~wd;
    endtask
endmodule

// ### tb_transceiver_reconfig_busy_timing.sv
`timescale 1ns/1ps
module tb_transceiver_reconfig_busy_timing
    import rcb_pkg::*;
;
    // Shortened counts keep the run brief; ch0 tx, ch1 rx, ch2 none, ch3 rx+tx.
    localparam int OC_RX = 30;
    localparam int SETTLE = 40;
    localparam int RC_RX = 21;
    localparam int RC_TXRX = 22;
    localparam int RC_FULL = 23;
    localparam logic [7:0] CHT = 8'hc9;
    logic mclk_i;
    logic srst_i = 1'b1;
    logic busy_o;
    logic data_valid_o;
    logic r_busy;
    rcb_ahb_req_t host_req;
    rcb_ahb_req_t ahb_req;
    rcb_ahb_rsp_t ahb_rsp;
    int fail_count = 0;
    int num_checks = 0;
    int r_cnt = 0;
    int rb_m[NUM_CH] = '{0, 0, 0, 0};
    int rk[7] = '{DUR_RC_TX, RC_RX, RC_TXRX, DUR_RC_PLL, DUR_RC_TXPLL, RC_FULL, DUR_RC_CLK_UNIT};
    logic [31:0] rd;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Clock and the single-slave hready loop.
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    always_comb begin
        ahb_req = host_req;
        ahb_req.hready = ahb_rsp.hreadyout;
    end

    rcb_host_mdl u_host (.mclk_i(mclk_i), .req_o(host_req), .rsp_i(ahb_rsp));
    rcb_ctrl #(.OC_RX_CYC(OC_RX), .OC_SETTLE_CYC(SETTLE), .RC_RX_CYC(RC_RX),
        .RC_TXRX_CYC(RC_TXRX), .RC_FULL_CYC(RC_FULL), .CH_TYPES_INIT(CHT)) dut_u (
        .mclk_i(mclk_i), .srst_i(srst_i), .ahb_req_i(ahb_req), .ahb_rsp_o(ahb_rsp),
        .busy_o(busy_o), .data_valid_o(data_valid_o));
    // The reduced-timing copy only runs its power-up cancellation; its bus stays idle.
    rcb_ctrl #(.REDUCED_TIMING(1'b1), .CH_TYPES_INIT(CHT)) dut_r (
        .mclk_i(mclk_i), .srst_i(srst_i), .ahb_req_i('0), .ahb_rsp_o(),
        .busy_o(r_busy), .data_valid_o());
    always @(negedge mclk_i) if (r_busy === 1'b1) r_cnt++;

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Expected cancellation length from the channel map.
    function automatic int oc_exp();
        int s;
        s = SETTLE;
        for (int c = 0; c < NUM_CH; c++) begin
            case (CHT[2*c+:2])
                CHT_TX: s += DUR_OC_TX;
                CHT_NONE: s += DUR_OC_NONE;
                default: s += OC_RX;
            endcase
        end
        return s;
    endfunction

    function automatic logic [31:0] rb_word();
        logic [31:0] s;
        s = '0;
        for (int c = 0; c < NUM_CH; c++) s |= 32'(rb_m[c]) << (VAL_W * c);
        return s;
    endfunction

    // Counts busy cycles at falling edges, so no sample races the design's flops.
    task automatic meas(input int n, input logic dv);
        int k;
        k = 0;
        @(negedge mclk_i);
        repeat (4) if (busy_o !== 1'b1) @(negedge mclk_i);
        while (busy_o === 1'b1 && k < 300000) begin
            k++;
            @(negedge mclk_i);
        end
        check(k, n);
        check(data_valid_o, dv);
        @(posedge mclk_i);
    endtask

    // Issues a command, measures busy, then compares the recorded duration.
    task automatic cmd(input int op, ctl, al, ch, kind, n, input logic dv);
        logic [31:0] w;
        w = (32'(op) << CMD_OP_LSB) | (32'(kind) << CMD_KIND_LSB) | (32'(ch) << CMD_CH_LSB);
        w |= (32'(al) << CMD_ALL_BIT) | 32'(ctl);
        u_host.xfer(1'b1, RCB_CMD_OFS, w, rd);
        meas(n, dv);
        u_host.xfer(1'b0, RCB_DUR_OFS, 32'h0, rd);
        if (n > 0) check(rd, n);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        int v;
        int c;
        v = $urandom(32'h34a318c1);
        repeat (3) @(posedge mclk_i);
        srst_i <= 1'b0;
        // The cycle right after release is the quiet one.
        @(negedge mclk_i);
        check(busy_o, 1'b0);
        meas(oc_exp(), 1'b0);
        u_host.xfer(1'b0, RCB_STATUS_OFS, 32'h0, rd);
        check(rd, 32'h4);
        $display("test power_up done");
        for (int t = 0; t < NUM_CTL; t++) begin
            v = $urandom % 32;
            c = $urandom % NUM_CH;
            rb_m[c] = v;
            u_host.xfer(1'b1, RCB_WDATA_OFS, 32'(v), rd);
            cmd(0, t, 0, c, 0, (t >= 4) ? DUR_WR_LONG : DUR_WR_SHORT, 1'b0);
            cmd(1, t, 0, c, 0, (t >= 4) ? DUR_RD_LONG : DUR_RD_SHORT, 1'b1);
            u_host.xfer(1'b0, RCB_RBACK_OFS, 32'h0, rd);
            check(rd, rb_word());
            u_host.xfer(1'b0, RCB_CMD_OFS, 32'h0, rd);
            check(rd, (32'(OP_PMA_RD) << CMD_OP_LSB) | (32'(c) << CMD_CH_LSB) | 32'(t));
        end
        $display("test single_channel done");
        v = $urandom % 32;
        for (int k = 0; k < NUM_CH; k++) rb_m[k] = v;
        u_host.xfer(1'b1, RCB_WDATA_OFS, 32'(v), rd);
        cmd(0, 5, 1, 0, 0, 4 * DUR_WR_LONG, 1'b0);
        cmd(0, 1, 1, 0, 0, 4 * DUR_WR_SHORT, 1'b0);
        cmd(1, 5, 1, 0, 0, 4 * DUR_RD_LONG, 1'b1);
        cmd(1, 1, 1, 0, 0, 4 * DUR_RD_SHORT, 1'b1);
        u_host.xfer(1'b0, RCB_RBACK_OFS, 32'h0, rd);
        check(rd, rb_word());
        $display("test broadcast done");
        for (int k = 0; k < 7; k++) cmd(2, 0, 0, 0, k, rk[k], 1'b0);
        $display("test reconfig done");
        // A second command during busy is refused and must not stretch the first.
        u_host.xfer(1'b1, RCB_CMD_OFS, 32'h0, rd);
        u_host.xfer(1'b1, RCB_CMD_OFS, 32'h4, rd);
        meas(DUR_WR_SHORT - 2, 1'b0);
        u_host.xfer(1'b0, RCB_STATUS_OFS, 32'h0, rd);
        check(rd, 32'hc);
        u_host.xfer(1'b1, RCB_STATUS_OFS, 32'h8, rd);
        u_host.xfer(1'b0, RCB_STATUS_OFS, 32'h0, rd);
        check(rd, 32'h4);
        cmd(0, 6, 0, 0, 0, 0, 1'b0);
        cmd(2, 0, 0, 0, 7, 0, 1'b0);
        u_host.xfer(1'b0, RCB_STATUS_OFS, 32'h0, rd);
        check(rd, 32'hc);
        u_host.xfer(1'b0, 8'h3c, 32'h0, rd);
        check(rd, 32'h0);
        $display("test refusal done");
        cmd(3, 0, 0, 0, 0, oc_exp(), 1'b0);
        check(r_cnt, DUR_OC_SIM);
        $display("test rerun done");
        give_verdict();
    end

    // Watchdog well beyond the roughly sixteen thousand cycles the tests need.
    initial begin
        #1000000;
        fail_count++;
        give_verdict();
    end
endmodule
